// [rtl/brs_pkg.sv]
// Package with constants and types for the boot region swap remap block
//
// Contract
// - Swap inverts size-selected address bit, top regions
// - Swap clear passes every address unchanged
// - Code 000 swaps FFFF_0000h with FFFE_0000h
// - Code 001 swaps FFFE_0000h with FFFC_0000h
// - Code 010 swaps FFFC_0000h with FFF8_0000h
// - Code 011 swaps FFF8_0000h with FFF0_0000h
// - Code 100 swaps FFF0_0000h with FFE0_0000h
// - Code 101 swaps FFE0_0000h with FFC0_0000h
// - Code 110 swaps FFC0_0000h with FF80_0000h
// - Code 111 swaps FF80_0000h with FF00_0000h
// - Well reset clears swap; platform reset keeps
// - Swap bit lives in battery-backed well
// - Strap forces swap set; clears ignored
package brs_pkg;
  localparam int unsigned BRS_ADDR_W = 32;
  localparam int unsigned BRS_BASE_BIT = 16;
  localparam logic [2:0] BRS_SIZE_RST = 3'h0;
  localparam logic BRS_SWAP_RST = 1'b0;
  localparam logic BRS_LOCK_RST = 1'b0;
  localparam logic [7:0] BRS_TOP_BYTE = 8'hff;

  typedef enum {BRS_IDLE, BRS_BUSY} brs_state_e;

  typedef struct packed {
    logic valid;
    logic toFlash;
    logic [BRS_ADDR_W-1:0] addr;
  } brs_cycle_s;

  typedef struct packed {
    logic swapEn;
    logic lockEn;
    logic wrSwap;
    logic wrLock;
  } brs_swwr_s;
endpackage

// [rtl/brs_swap_well.sv]
// Battery-backed swap and lock bits
`timescale 1ns/1ns
`default_nettype none
module brs_swap_well
  import brs_pkg::*;
(
  input wire logic mclk,
  input wire logic rtc_well_reset_n,
  input wire logic strapSwap,
  input wire brs_pkg::brs_swwr_s swWr,
  output logic swapBit,
  output logic lockBit
);
  logic swap_r;
  logic lock_r;

  // Only the well reset touches these; platform reset is not wired
  always_ff @(posedge mclk or negedge rtc_well_reset_n) begin
    if (!rtc_well_reset_n) begin
      lock_r <= BRS_LOCK_RST;
    end else if (swWr.wrLock && swWr.lockEn) begin
      lock_r <= 1'b1; // Sticky until well reset
    end
  end

  always_ff @(posedge mclk or negedge rtc_well_reset_n) begin
    if (!rtc_well_reset_n) begin
      swap_r <= BRS_SWAP_RST;
    end else if (strapSwap) begin
      swap_r <= 1'b1;
    end else if (swWr.wrSwap && !lock_r) begin
      swap_r <= swWr.swapEn;
    end
  end

  assign swapBit = swap_r;
  assign lockBit = lock_r;

  a_strap_force: assert property (@(posedge mclk) disable iff (!rtc_well_reset_n)
    strapSwap |=> swap_r) else $error("strap did not force swap");
  a_lock_hold: assert property (@(posedge mclk) disable iff (!rtc_well_reset_n)
    (lock_r && !strapSwap) |=> $stable(swap_r)) else $error("locked swap changed");
endmodule
`default_nettype wire

// [rtl/brs_remap.sv]
// Combinational address exchange for the boot regions
`timescale 1ns/1ns
`default_nettype none
module brs_remap
  import brs_pkg::*;
(
  input wire logic swapOn,
  input wire logic [2:0] sizeCode,
  input wire brs_pkg::brs_cycle_s cycIn,
  output brs_pkg::brs_cycle_s cycOut
);
  logic [BRS_ADDR_W-1:0] flipMask;
  logic [BRS_ADDR_W-1:0] regionMask;
  logic inWindow;

  // Flip bit is base plus size code; window is two regions below the top
  always_comb begin
    flipMask = '0;
    flipMask[BRS_BASE_BIT + int'(sizeCode)] = 1'b1;
    regionMask = ~((flipMask << 1) - 32'h1);
    inWindow = ((cycIn.addr & regionMask) == regionMask);
  end

  // One mask covers every size code row
  always_comb begin
    cycOut = cycIn;
    if (swapOn && cycIn.toFlash && inWindow) begin
      cycOut.addr = cycIn.addr ^ flipMask;
    end
  end
endmodule
`default_nettype wire

// [rtl/brs_top.sv]
// Top of the boot region swap remap block
`timescale 1ns/1ns
`default_nettype none
module brs_top
  import brs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic rtc_well_reset_n,
  input wire logic platform_reset_n,
  input wire logic strapSwap,
  input wire logic [2:0] bootSizeCode,
  input wire logic swWrSwap,
  input wire logic swWrLock,
  input wire logic swSwapData,
  input wire logic swLockData,
  input wire brs_pkg::brs_cycle_s hostCyc,
  output brs_pkg::brs_cycle_s outCyc,
  output logic swapState,
  output logic lockState
);
  brs_state_e state_r;
  logic swapBit;
  logic lockBit;
  logic [2:0] size_r;
  brs_cycle_s remapped;
  brs_cycle_s out_r;
  brs_swwr_s wr;
  logic platRst;

  // Software writes only land while platform is out of reset
  assign platRst = !(rstn && platform_reset_n);
  assign wr = '{swapEn: swSwapData, lockEn: swLockData,
                wrSwap: swWrSwap && !platRst, wrLock: swWrLock && !platRst};

  brs_swap_well uWell (
    .mclk(mclk),
    .rtc_well_reset_n(rtc_well_reset_n),
    .strapSwap(strapSwap),
    .swWr(wr),
    .swapBit(swapBit),
    .lockBit(lockBit)
  );

  // Soft strap is caught once after platform reset release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= BRS_IDLE;
    end else if (!platform_reset_n) begin
      state_r <= BRS_IDLE;
    end else begin
      case (state_r)
        BRS_IDLE: state_r <= BRS_BUSY;
        BRS_BUSY: state_r <= BRS_BUSY;
        default: state_r <= BRS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      size_r <= BRS_SIZE_RST;
    end else if (state_r == BRS_IDLE) begin
      size_r <= bootSizeCode;
    end
  end

  brs_remap uRemap (
    .swapOn(swapBit),
    .sizeCode(size_r),
    .cycIn(hostCyc),
    .cycOut(remapped)
  );

  // Registered output stage; one cycle of latency
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_r <= '0;
    end else begin
      out_r <= remapped;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      swapState <= BRS_SWAP_RST;
      lockState <= BRS_LOCK_RST;
    end else begin
      swapState <= swapBit;
      lockState <= lockBit;
    end
  end

  assign outCyc = out_r;

  a_pass_clear: assert property (@(posedge mclk) disable iff (!rstn)
    !swapBit |=> (out_r.addr == $past(hostCyc.addr))) else $error("address changed");
  a_nonflash_pass: assert property (@(posedge mclk) disable iff (!rstn)
    !hostCyc.toFlash |=> (out_r.addr == $past(hostCyc.addr))) else $error("non flash remapped");
  a_size0_swap: assert property (@(posedge mclk) disable iff (!rstn)
    (swapBit && hostCyc.toFlash && size_r == 3'h0 && hostCyc.addr[31:16] == 16'hffff)
    |=> (out_r.addr[31:16] == 16'hfffe)) else $error("64k swap wrong");
  a_size1_swap: assert property (@(posedge mclk) disable iff (!rstn)
    (swapBit && hostCyc.toFlash && size_r == 3'h1 && hostCyc.addr[31:17] == 15'h7ffe)
    |=> (out_r.addr[31:17] == 15'h7fff)) else $error("128k swap wrong");
  a_size7_swap: assert property (@(posedge mclk) disable iff (!rstn)
    (swapBit && hostCyc.toFlash && size_r == 3'h7 && hostCyc.addr[31:23] == 9'h1ff)
    |=> (out_r.addr[31:23] == 9'h1fe)) else $error("8m swap wrong");
  a_size4_swap: assert property (@(posedge mclk) disable iff (!rstn)
    (swapBit && hostCyc.toFlash && size_r == 3'h4 && hostCyc.addr[31:20] == 12'hffe)
    |=> (out_r.addr[31:20] == 12'hfff)) else $error("1m swap wrong");
  a_outside_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (hostCyc.addr[31:24] != BRS_TOP_BYTE) |=> (out_r.addr == $past(hostCyc.addr)))
    else $error("outside window remapped");
  a_state_mirror: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 (swapState == $past(swapBit))) else $error("swap state lags");
endmodule
`default_nettype wire

// [tb/brs_flash_model.sv]
// Serial flash stand-in that logs flash-bound cycles
`timescale 1ns/1ns
`default_nettype none
module brs_flash_model
  import brs_pkg::*;
(
  input wire logic mclk,
  input wire brs_pkg::brs_cycle_s cyc,
  output logic [31:0] lastAddr,
  output var int hits
);
  initial lastAddr = 32'h0;
  initial hits = 0;
  // Counts only valid flash cycles, so a stray extra cycle shows up
  always @(posedge mclk) begin
    if (cyc.valid && cyc.toFlash) begin
      lastAddr <= cyc.addr;
      hits <= hits + 1;
    end
  end
endmodule
`default_nettype wire

// [tb/boot_region_swap_remap_tb.sv]
// Bench for the boot region swap remap block
`timescale 1ns/1ns
`default_nettype none
module boot_region_swap_remap_tb;
  import brs_pkg::*;
  logic mclk, rstn, rtc_well_reset_n, platform_reset_n, strapSwap;
  logic swWrSwap, swWrLock, swSwapData, swLockData, swapState, lockState;
  logic [2:0] sizeCode;
  logic [31:0] flashAddr;
  brs_cycle_s hostCyc, outCyc;
  int flashHits, nFlash = 0, ticks = 0, errTotal = 0, totalChecks = 0;
  brs_top DUT (.mclk(mclk), .rstn(rstn), .rtc_well_reset_n(rtc_well_reset_n),
    .platform_reset_n(platform_reset_n), .strapSwap(strapSwap), .bootSizeCode(sizeCode),
    .swWrSwap(swWrSwap), .swWrLock(swWrLock), .swSwapData(swSwapData),
    .swLockData(swLockData), .hostCyc(hostCyc), .outCyc(outCyc),
    .swapState(swapState), .lockState(lockState));
  brs_flash_model flash (.mclk(mclk), .cyc(outCyc), .lastAddr(flashAddr), .hits(flashHits));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 2000) begin
      errTotal++;
      finalReport();
    end
  end
  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Valid for one cycle only, so the flash log counts each cycle once
  task automatic hostCycle(input logic [31:0] a, input logic fl, input logic [31:0] exp);
    @(posedge mclk) hostCyc <= '{1'b1, fl, a};
    @(posedge mclk) hostCyc <= '0;
    #1 chk(outCyc.addr, exp);
    if (fl) nFlash++;
  endtask
  task automatic swWrite(input logic lk, input logic d, input logic [1:0] exp);
    @(posedge mclk);
    swWrSwap <= !lk;
    swWrLock <= lk;
    swSwapData <= d;
    swLockData <= d;
    @(posedge mclk);
    swWrSwap <= 1'b0;
    swWrLock <= 1'b0;
    @(posedge mclk);
    #1 chk({30'h0, swapState, lockState}, {30'h0, exp});
  endtask
  // Size is only taken after a platform reset release
  task automatic pltPulse(input logic [2:0] c);
    @(posedge mclk);
    sizeCode <= c;
    platform_reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    platform_reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  initial begin
    logic [31:0] m;
    {rstn, rtc_well_reset_n, platform_reset_n, strapSwap} = 4'h0;
    {swWrSwap, swWrLock, swSwapData, swLockData} = 4'h0;
    sizeCode = 3'h0;
    hostCyc = '0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rtc_well_reset_n <= 1'b1;
    pltPulse(3'h0);
    hostCycle(32'hffff_fff0, 1'b1, 32'hffff_fff0);
    swWrite(1'b0, 1'b1, 2'b10);
    for (int c = 0; c < 8; c++) begin
      pltPulse(c[2:0]);
      m = 32'h1 << (16 + c);
      #1 chk({31'h0, swapState}, 32'h1);
      hostCycle(32'hffff_fff0, 1'b1, 32'hffff_fff0 ^ m);
      hostCycle(32'hffff_fff0 ^ m, 1'b1, 32'hffff_fff0);
      hostCycle(32'hffff_fff0 ^ (m << 1), 1'b1, 32'hffff_fff0 ^ (m << 1));
      hostCycle(32'hffff_fff0, 1'b0, 32'hffff_fff0);
    end
    $display("test remap done");
    swWrite(1'b0, 1'b0, 2'b00);
    swWrite(1'b1, 1'b1, 2'b01);
    swWrite(1'b0, 1'b1, 2'b01);
    @(posedge mclk) strapSwap <= 1'b1;
    swWrite(1'b0, 1'b0, 2'b11);
    @(posedge mclk) strapSwap <= 1'b0;
    $display("test lock and strap done");
    @(posedge mclk) rtc_well_reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rtc_well_reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({30'h0, swapState, lockState}, 32'h0);
    swWrite(1'b0, 1'b1, 2'b10);
    // Writes while the platform sits in reset must not land
    @(posedge mclk) platform_reset_n <= 1'b0;
    swWrite(1'b0, 1'b0, 2'b10);
    @(posedge mclk) platform_reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(flashHits, nFlash);
    $display("test well reset done");
    finalReport();
  end
endmodule
`default_nettype wire
